// file: ufc_uart_fifo_ctrl.sv
`timescale 1ns/1ps
module ufc_uart_fifo_ctrl
    import ufc_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic [7:0] tx_data,
    output logic tx_valid,
    input wire logic tx_ready,
    input wire logic [7:0] rx_data,
    input wire logic rx_valid,
    output logic rx_ready,
    input wire logic rx_timeout,
    output logic tx_dma_ready_n,
    output logic multi_function_pin,
    output logic rx_data_irq,
    output logic tx_space_irq
);

    // software visible state
    logic [7:0] fifo_control;
    logic [7:0] alternate_function_cfg;

    // registered receive ready level, before pin selection
    logic rx_dma_ready_n;

    // block mode receive ready state
    ufc_rxdma_t rxd_state;
    ufc_rxdma_t next_rxd_state;

    // read of the receive holding word, armed in the setup phase
    logic rx_take;

    // fifo side signals
    logic tx_in_ready;
    logic [4:0] tx_count;
    logic [4:0] rx_count;
    logic rx_in_ready;

    // receive fifo head as the bus sees it
    logic [7:0] rx_head;
    logic rx_head_valid;

    // ------------------------------------------------------------
    // apb decode
    // ------------------------------------------------------------

    // the answer always comes in the first access cycle
    wire setup = psel && !penable;
    wire access = psel && penable && pready;
    // pready in the term keeps a held access from acting twice
    wire wr_access = access && pwrite;

    // register hits
    // exact byte addresses: a misaligned address is refused
    wire hit_fc = (paddr == OFF_FIFO_CONTROL);
    wire hit_tx = (paddr == OFF_TX_HOLDING);
    wire hit_rx = (paddr == OFF_RX_HOLDING);
    wire hit_af = (paddr == OFF_ALT_FUNC);
    wire hit_st = (paddr == OFF_STATUS);
    wire mapped = hit_fc || hit_tx || hit_rx || hit_af || hit_st;

    // refused: unmapped, wrong direction, or write into a full transmit path
    // a refused write changes nothing; the error is its only answer
    wire bad_dir = pwrite ? (hit_rx || hit_st) : hit_tx;
    wire tx_overrun = pwrite && hit_tx && !tx_in_ready;
    wire next_err = !mapped || bad_dir || tx_overrun;

    // byte registers only move when lane zero is strobed
    // a write with lane zero off does nothing; it ends without error unless refused above
    wire lane0 = pstrb[0];
    wire fc_write = wr_access && hit_fc && lane0 && !pslverr;
    wire af_write = wr_access && hit_af && lane0 && !pslverr;
    // tx ready can only rise between setup and access, so the check holds
    wire tx_push = wr_access && hit_tx && lane0 && !pslverr;
    // rx_take keeps an empty fifo from being popped
    wire rx_pop = access && rx_take;

    // ------------------------------------------------------------
    // fifo control decode
    // ------------------------------------------------------------

    // block mode needs the fifos; with them off the mode bit waits
    wire fifo_en = fifo_control[FC_EN];
    wire mode1 = fifo_en && fifo_control[FC_DMA_MODE];
    wire [1:0] trig_sel = fifo_control[FC_TRIG_HI:FC_TRIG_LO];

    // trigger level in characters
    // compared as a level, so a burst past the mark still triggers
    wire [4:0] trig_level = (trig_sel == 2'b00) ? TRIG_SEL0 :
                            (trig_sel == 2'b01) ? TRIG_SEL1 :
                            (trig_sel == 2'b10) ? TRIG_SEL2 :
                                                  TRIG_SEL3;

    // fifos off behave as a single holding register
    // limitation: with fifos off only one character waits each way
    wire [4:0] fill_limit = fifo_en ? LIMIT_FIFO : LIMIT_HOLD;

    // an enable change empties both fifos, just as the flush bits do
    // old characters are never read back under a changed depth
    wire en_change = fc_write && (pwdata[FC_EN] != fifo_en);

    // with enable written low only the enable bit moves
    // so software can switch the fifos off without losing its setup
    wire [7:0] fc_kept = fifo_control & ~(8'h01 << FC_EN);
    wire [7:0] fc_loaded = pwdata[7:0] & FC_WRITE_MASK;
    wire [7:0] fc_written = pwdata[FC_EN] ? fc_loaded : fc_kept;

    // flush bits live for one cycle only
    // the fifos act on a flush one edge after the write lands
    wire [7:0] fc_idle = fifo_control &
        ~((8'h01 << FC_RX_FLUSH) | (8'h01 << FC_TX_FLUSH));
    wire [7:0] flush_force = en_change ?
        ((8'h01 << FC_RX_FLUSH) | (8'h01 << FC_TX_FLUSH)) : 8'h00;
    wire [7:0] next_fc = (fc_write ? fc_written : fc_idle) | flush_force;

    // flush requests reach the fifos from the register itself
    wire rx_flush = fifo_control[FC_RX_FLUSH];
    wire tx_flush = fifo_control[FC_TX_FLUSH];

    // ------------------------------------------------------------
    // status derived from fill levels
    // ------------------------------------------------------------

    // counts are registered, so every level lags a push by one cycle
    wire tx_empty = (tx_count == CNT_EMPTY);
    wire tx_full = (tx_count == LIMIT_FIFO);
    wire rx_empty = (rx_count == CNT_EMPTY);
    wire rx_at_trig = (rx_count >= trig_level);

    // transmit ready: mode 1 is high only when full, mode 0 high once loaded
    // mode 0 ignores depth and only asks whether anything is held
    wire next_tx_rdy_n = mode1 ? tx_full : !tx_empty;

    // block mode receive ready walks from trigger/timeout to empty
    always_comb begin
        next_rxd_state = rxd_state;
        case (rxd_state)
            UFC_RXD_IDLE: begin
                // an arriving trigger or timeout starts the block
                if (mode1 && (rx_at_trig || rx_timeout)) begin
                    next_rxd_state = UFC_RXD_ACTIVE;
                end
            end
            UFC_RXD_ACTIVE: begin
                // held until the fifo drains; a fresh timeout keeps it
                if (!mode1) begin
                    // leaving block mode drops the block at once
                    next_rxd_state = UFC_RXD_IDLE;
                end else if (rx_empty && !rx_timeout) begin
                    next_rxd_state = UFC_RXD_IDLE;
                end
            end
            default: begin
                // unreachable with two states; recovers to idle
                next_rxd_state = UFC_RXD_IDLE;
            end
        endcase
    end

    // mode 0 follows the receiver's content directly
    // the next state is used so pin and state move on the same edge
    wire next_rx_rdy_n = mode1 ? (next_rxd_state != UFC_RXD_ACTIVE) : rx_empty;

    // the pin carries receive ready only while software selected it;
    // software must select it before trusting the pin
    // otherwise the pin is a plain level set by software
    wire next_mf = alternate_function_cfg[AF_RX_READY] ?
        next_rx_rdy_n : alternate_function_cfg[AF_LEVEL];

    // interrupt levels: receive at the trigger in mode 1, per character in mode 0; transmit on any room in mode 1, only when empty in mode 0
    // both are levels; latching and priority live outside this block
    wire next_rx_irq = mode1 ? (rx_at_trig || rx_timeout) : !rx_empty;
    wire next_tx_irq = mode1 ? !tx_full : tx_empty;

    // ------------------------------------------------------------
    // read data mux
    // ------------------------------------------------------------

    // status is a snapshot of registered levels taken at setup
    wire [31:0] status_word =
        (32'(tx_count) << ST_TX_CNT) |
        (32'(rx_count) << ST_RX_CNT) |
        (32'(tx_dma_ready_n) << ST_TX_RDY_N) |
        (32'(rx_dma_ready_n) << ST_RX_RDY_N) |
        (32'(rx_data_irq) << ST_RX_IRQ) |
        (32'(tx_space_irq) << ST_TX_IRQ) |
        (32'(rxd_state == UFC_RXD_ACTIVE) << ST_RX_BLOCK);

    // an empty receive path reads as zero and pops nothing
    wire [31:0] rx_word = rx_head_valid ? {24'h000000, rx_head} : 32'h00000000;
    wire [31:0] rd_mux = hit_fc ? {24'h000000, fifo_control} :
                         hit_af ? {24'h000000, alternate_function_cfg} :
                         hit_rx ? rx_word :
                         hit_st ? status_word : 32'h00000000;
    // the pop is armed at setup, so the word read is the word removed
    wire arm_take = setup && !pwrite && hit_rx && rx_head_valid;

    // ------------------------------------------------------------
    // apb answer registers
    // ------------------------------------------------------------

    // setup loads the answer; the access cycle presents it
    // one pulse of pready per transfer, so there is never a wait state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
            rx_take <= 1'b0;
        end else begin
            pready <= setup;
            pslverr <= setup && next_err;
            // read data rests at zero outside the access cycle
            prdata <= (setup && !pwrite) ? rd_mux : 32'h00000000;
            rx_take <= arm_take;
        end
    end

    // ------------------------------------------------------------
    // control registers
    // ------------------------------------------------------------

    // all control state starts at zero: fifos off, mode 0, trigger one
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fifo_control <= FC_RESET;
            alternate_function_cfg <= AF_RESET;
        end else begin
            // flush bits fall by themselves through next_fc
            fifo_control <= next_fc;
            if (af_write) begin
                // only the two defined bits of the pin function are kept
                alternate_function_cfg <= pwdata[7:0] & AF_WRITE_MASK;
            end
        end
    end

    // ------------------------------------------------------------
    // pin and level outputs
    // ------------------------------------------------------------

    // receive ready idles high and transmit ready low, nothing buffered after reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rxd_state <= UFC_RXD_IDLE;
            // transmit ready starts low: nothing held, so there is room
            tx_dma_ready_n <= 1'b0;
            rx_dma_ready_n <= 1'b1;
            // the pin is a low level until software picks its function
            multi_function_pin <= 1'b0;
            rx_data_irq <= 1'b0;
            tx_space_irq <= 1'b0;
        end else begin
            rxd_state <= next_rxd_state;
            tx_dma_ready_n <= next_tx_rdy_n;
            rx_dma_ready_n <= next_rx_rdy_n;
            multi_function_pin <= next_mf;
            rx_data_irq <= next_rx_irq;
            tx_space_irq <= next_tx_irq;
        end
    end

    // ------------------------------------------------------------
    // data buffers
    // ------------------------------------------------------------

    // transmit path: bus fills, transmit serializer drains at its own pace
    // the head word sits in a flop, so tx_data leaves a register
    ufc_fifo #(
        .WIDTH(DATA_W),
        .DEPTH(FIFO_DEPTH),
        .CW(CNT_W),
        .PW(PTR_W)
    ) u_tx_fifo (
        .pclk(pclk),
        .presetn(presetn),
        .flush(tx_flush),
        .limit(fill_limit),
        .in_valid(tx_push),
        .in_data(pwdata[7:0]),
        .in_ready(tx_in_ready),
        .out_valid(tx_valid),
        .out_data(tx_data),
        .out_ready(tx_ready),
        .count(tx_count)
    );

    // receive path: receiver fills and is stalled by rx_ready when full;
    // the serializer itself is never touched by a flush
    // a bus read pops through out_ready only in the access cycle
    ufc_fifo #(
        .WIDTH(DATA_W),
        .DEPTH(FIFO_DEPTH),
        .CW(CNT_W),
        .PW(PTR_W)
    ) u_rx_fifo (
        .pclk(pclk),
        .presetn(presetn),
        .flush(rx_flush),
        .limit(fill_limit),
        .in_valid(rx_valid),
        .in_data(rx_data),
        .in_ready(rx_in_ready),
        .out_valid(rx_head_valid),
        .out_data(rx_head),
        .out_ready(rx_pop),
        .count(rx_count)
    );

    // back-pressure straight from the fifo's registered ready
    // limitation: a full receive fifo stalls the receiver, nothing is lost
    assign rx_ready = rx_in_ready;

endmodule

// file: ufc_pkg.sv
package ufc_pkg;

    // character and buffer geometry
    localparam int unsigned DATA_W = 8;
    localparam int unsigned FIFO_DEPTH = 16;
    localparam int unsigned CNT_W = 5;
    localparam int unsigned PTR_W = 4;

    // apb geometry
    localparam int unsigned ADDR_W = 12;
    localparam int unsigned BUS_W = 32;

    // register byte offsets
    localparam logic [11:0] OFF_FIFO_CONTROL = 12'h000;
    localparam logic [11:0] OFF_TX_HOLDING = 12'h004;
    localparam logic [11:0] OFF_RX_HOLDING = 12'h008;
    localparam logic [11:0] OFF_ALT_FUNC = 12'h00C;
    localparam logic [11:0] OFF_STATUS = 12'h010;

    // fifo_control field positions
    localparam int unsigned FC_EN = 0;
    localparam int unsigned FC_RX_FLUSH = 1;
    localparam int unsigned FC_TX_FLUSH = 2;
    localparam int unsigned FC_DMA_MODE = 3;
    localparam int unsigned FC_TRIG_LO = 6;
    localparam int unsigned FC_TRIG_HI = 7;
    localparam logic [7:0] FC_RESET = 8'h00;
    localparam logic [7:0] FC_WRITE_MASK = 8'hCF;

    // alternate_function_cfg fields
    localparam int unsigned AF_RX_READY = 0;
    localparam int unsigned AF_LEVEL = 1;
    localparam logic [7:0] AF_RESET = 8'h00;
    localparam logic [7:0] AF_WRITE_MASK = 8'h03;

    // status field positions
    localparam int unsigned ST_TX_CNT = 0;
    localparam int unsigned ST_RX_CNT = 8;
    localparam int unsigned ST_TX_RDY_N = 16;
    localparam int unsigned ST_RX_RDY_N = 17;
    localparam int unsigned ST_RX_IRQ = 18;
    localparam int unsigned ST_TX_IRQ = 19;
    localparam int unsigned ST_RX_BLOCK = 20;

    // receive trigger levels in characters
    localparam logic [4:0] TRIG_SEL0 = 5'h01;
    localparam logic [4:0] TRIG_SEL1 = 5'h04;
    localparam logic [4:0] TRIG_SEL2 = 5'h08;
    localparam logic [4:0] TRIG_SEL3 = 5'h0E;

    // fill limits: full fifo, or one-deep holding register
    localparam logic [4:0] LIMIT_FIFO = 5'h10;
    localparam logic [4:0] LIMIT_HOLD = 5'h01;
    localparam logic [4:0] CNT_EMPTY = 5'h00;

    // receive ready state in block mode
    typedef enum logic {
        UFC_RXD_IDLE,
        UFC_RXD_ACTIVE
    } ufc_rxdma_t;

endpackage

// file: ufc_fifo.sv
`timescale 1ns/1ps
module ufc_fifo
    import ufc_pkg::*;
#(
    parameter int unsigned WIDTH = 8,
    parameter int unsigned DEPTH = 16,
    parameter int unsigned CW = 5,
    parameter int unsigned PW = 4
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic flush,
    input wire logic [CW-1:0] limit,
    input wire logic in_valid,
    input wire logic [WIDTH-1:0] in_data,
    output logic in_ready,
    output logic out_valid,
    output logic [WIDTH-1:0] out_data,
    input wire logic out_ready,
    output logic [CW-1:0] count
);

    // storage; depth must be a power of two so pointers wrap by themselves
    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW-1:0] wr_ptr;
    logic [PW-1:0] rd_ptr;

    // a flush drops the incoming word so nothing survives the clear
    wire push = in_valid && in_ready && !flush;
    wire pop = out_valid && out_ready && !flush;
    wire [PW-1:0] next_wr_ptr = flush ? '0 : (push ? PW'(wr_ptr + 1'b1) : wr_ptr);
    wire [PW-1:0] next_rd_ptr = flush ? '0 : (pop ? PW'(rd_ptr + 1'b1) : rd_ptr);
    wire [CW-1:0] next_count = flush ? '0 :
        CW'(count + CW'(push) - CW'(pop));
    // a word written where the next read points bypasses the array
    wire bypass = push && (wr_ptr == next_rd_ptr);

    // array write, no reset needed on the data
    always_ff @(posedge pclk) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end

    // pointers, count and registered handshake flags
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
            out_valid <= 1'b0;
            in_ready <= 1'b0;
        end else begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
            count <= next_count;
            out_valid <= (next_count != '0);
            in_ready <= (next_count < limit);
        end
    end

    // head word comes from a register, ready one cycle after a push
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            out_data <= '0;
        end else begin
            out_data <= bypass ? in_data : mem[next_rd_ptr];
        end
    end

endmodule

// file: ufc_far_model.sv
`timescale 1ns/1ps
// receiver and serializer stand-in on the stream side of the channel
module ufc_far_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic send,
    input wire logic stall,
    output logic [7:0] rx_data,
    output logic rx_valid,
    input wire logic rx_ready,
    input wire logic [7:0] tx_data,
    input wire logic tx_valid,
    output logic tx_ready,
    output logic [7:0] last,
    output logic [4:0] got
);
    logic [7:0] seq; // next character to offer
    // one character per send pulse, held until the channel takes it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_valid <= 1'h0;
            rx_data <= 8'h00;
            seq <= 8'hA0;
        end else if (rx_valid && rx_ready) begin
            rx_valid <= 1'h0;
            rx_data <= ~rx_data; // released line must not look valid
            seq <= seq + 8'h01;
        end else if (send) begin
            rx_valid <= 1'h1;
            rx_data <= seq;
        end
    end
    // drains transmit words unless stalled; stall lands one cycle late
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_ready <= 1'h0;
            last <= 8'h00;
            got <= 5'h00;
        end else begin
            tx_ready <= !stall;
            if (tx_valid && tx_ready) begin
                last <= tx_data;
                got <= got + 5'h01;
            end
        end
    end
endmodule

// file: ufc_uart_fifo_ctrl_assertions.sv
`timescale 1ns/1ps
// port-level checks; helper regs mirror accepted software writes
module ufc_uart_fifo_ctrl_assertions (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [7:0] tx_data,
    input wire logic tx_valid,
    input wire logic tx_ready,
    input wire logic rx_timeout,
    input wire logic tx_dma_ready_n,
    input wire logic multi_function_pin,
    input wire logic rx_data_irq,
    input wire logic tx_space_irq
);
    logic up; // low in the first cycle after reset, outputs still old
    logic [1:0] alt; // pin function as last written
    logic mode1; // block mode: enable and mode bit
    logic fc_wr; // a control write just landed, a flush may follow
    wire wr_ok = psel && penable && pready && pwrite && !pslverr;
    wire setup = psel && !penable;
    wire rd_bad = !pwrite && paddr == 12'h004;
    wire wr_bad = pwrite && (paddr == 12'h008 || paddr == 12'h010);
    wire bad = setup && (paddr > 12'h010 || rd_bad || wr_bad);
    // a write with enable low only clears enable, so mode falls too
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            up <= 1'h0;
            alt <= 2'h0;
            mode1 <= 1'h0;
            fc_wr <= 1'h0;
        end else begin
            up <= 1'h1;
            fc_wr <= wr_ok && paddr == 12'h000;
            if (wr_ok && paddr == 12'h00C) alt <= pwdata[1:0];
            if (wr_ok && paddr == 12'h000) mode1 <= pwdata[0] && pwdata[3];
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    apb_answer_a: assert property (setup |=> pready) else $error("no answer after setup");
    pready_single_a: assert property (pready |=> !pready) else $error("pready held");
    idle_quiet_a: assert property (!pready |-> prdata == 32'h0 && !pslverr)
        else $error("bus not quiet");
    refused_access_a: assert property (bad |=> pslverr) else $error("bad access accepted");
    tx_hold_a: assert property (tx_valid && !tx_ready && !fc_wr |=> tx_valid && $stable(tx_data))
        else $error("tx word dropped");
    tx_pair_a: assert property (up |-> tx_space_irq == !tx_dma_ready_n)
        else $error("tx ready and irq disagree");
    pin_level_a: assert property (up && !alt[0] && $stable(alt) |-> multi_function_pin == alt[1])
        else $error("pin not at level");
    rx_pin_m0_a: assert property (up && alt == 2'h1 && !mode1 && $stable(alt) && $stable(mode1)
        |-> multi_function_pin == !rx_data_irq) else $error("rx ready mode 0");
    rx_timeout_a: assert property (up && mode1 && $stable(mode1) && rx_timeout |=> rx_data_irq)
        else $error("timeout ignored");
    cover property (wr_ok && paddr == 12'h00C);
    cover property (mode1 && tx_dma_ready_n);
    cover property (bad);
endmodule
bind ufc_uart_fifo_ctrl ufc_uart_fifo_ctrl_assertions ufc_uart_fifo_ctrl_assertions_inst (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready), .rx_timeout(rx_timeout),
    .tx_dma_ready_n(tx_dma_ready_n), .multi_function_pin(multi_function_pin),
    .rx_data_irq(rx_data_irq), .tx_space_irq(tx_space_irq));

// file: uart_fifo_control_dma_ready_tb.sv
`timescale 1ns/1ps
// drives the channel over apb and feeds it through the far-side model
module uart_fifo_control_dma_ready_tb;
    logic pclk = 1'h0;
    logic presetn = 1'h0;
    logic [11:0] paddr = 12'h000;
    logic psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
    logic [31:0] pwdata = 32'h0, r, prdata;
    logic [3:0] pstrb = 4'hF; // byte lane tests left out for length
    logic rx_timeout = 1'h0, send = 1'h0, stall = 1'h0, e;
    logic pready, pslverr, tx_valid, tx_ready, rx_valid, rx_ready;
    logic tx_dma_ready_n, multi_function_pin, rx_data_irq, tx_space_irq;
    logic [7:0] tx_data, rx_data, last, x;
    logic [4:0] got;
    int errors = 0, n_tests = 0;
    typedef struct packed {
        logic w;
        logic [11:0] a;
        logic [31:0] d;
        logic [31:0] x;
        logic e;
    } ufc_row_t;
    // register cases: write, address, data, expected read, expected error
    ufc_row_t rows [10] = '{'{1'h0, 12'h000, 32'h0, 32'h00, 1'h0},
        '{1'h1, 12'h000, 32'hFF, 32'h0, 1'h0}, '{1'h0, 12'h000, 32'h0, 32'hC9, 1'h0},
        '{1'h1, 12'h000, 32'h08, 32'h0, 1'h0}, '{1'h0, 12'h000, 32'h0, 32'hC8, 1'h0},
        '{1'h1, 12'h00C, 32'h02, 32'h0, 1'h0}, '{1'h0, 12'h00C, 32'h0, 32'h02, 1'h0},
        '{1'h0, 12'h004, 32'h0, 32'h0, 1'h1}, '{1'h1, 12'h010, 32'h0, 32'h0, 1'h1},
        '{1'h0, 12'h020, 32'h0, 32'h0, 1'h1}};
    // receive cases: control value, level where pin drops, chars pushed
    logic [7:0] fcv [5] = '{8'h0B, 8'h4B, 8'h8B, 8'hCB, 8'hC3};
    int lv [5] = '{1, 4, 8, 14, 1};
    int np [5] = '{1, 4, 8, 14, 2};
    ufc_uart_fifo_ctrl ufc_uart_fifo_ctrl_inst (.pclk(pclk), .presetn(presetn), .paddr(paddr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .tx_data(tx_data),
        .tx_valid(tx_valid), .tx_ready(tx_ready), .rx_data(rx_data), .rx_valid(rx_valid),
        .rx_ready(rx_ready), .rx_timeout(rx_timeout), .tx_dma_ready_n(tx_dma_ready_n),
        .multi_function_pin(multi_function_pin), .rx_data_irq(rx_data_irq),
        .tx_space_irq(tx_space_irq));
    ufc_far_model ufc_far_model_inst (.pclk(pclk), .presetn(presetn), .send(send),
        .stall(stall), .rx_data(rx_data), .rx_valid(rx_valid), .rx_ready(rx_ready),
        .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready), .last(last), .got(got));
    always #2 pclk = ~pclk;
    task automatic results();
        if (errors == 0 && n_tests > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] w);
        n_tests++;
        if (g !== w) begin
            errors++;
            $display("BAD %0t got %h want %h", $time, g, w);
        end
    endtask
    // one transfer; an idle cycle after it keeps strobes from toggling twice
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        // no cycle count assumed: only the watchdog ends a hung wait
        do begin
            @(posedge pclk);
        end while (pready !== 1'h1);
        r = prdata;
        e = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        @(posedge pclk);
    endtask
    // offer one character and let the pins settle
    task automatic push();
        send <= 1'h1;
        @(posedge pclk);
        send <= 1'h0;
        repeat (5) @(posedge pclk);
    endtask
    initial begin
        repeat (20000) @(posedge pclk);
        errors++;
        results();
    end
    initial begin
        x = 8'hA0;
        repeat (12) @(posedge pclk);
        presetn <= 1'h1;
        @(posedge pclk);
        foreach (rows[i]) begin
            apb(rows[i].w, rows[i].a, rows[i].d);
            chk(32'(e), 32'(rows[i].e));
            if (!rows[i].w && !rows[i].e) chk(r, rows[i].x);
        end
        apb(1'h1, 12'h00C, 32'h01);
        for (int t = 0; t < 5; t++) begin
            apb(1'h1, 12'h000, 32'(fcv[t]));
            for (int k = 1; k <= np[t]; k++) begin
                push();
                chk(32'({multi_function_pin, rx_data_irq}), 32'({k < lv[t], k >= lv[t]}));
            end
            for (int k = 1; k <= np[t]; k++) begin
                apb(1'h0, 12'h008, 32'h0);
                chk(r, 32'(x));
                x++;
                repeat (2) @(posedge pclk);
                chk(32'(multi_function_pin), 32'(k == np[t]));
            end
        end
        push();
        push();
        apb(1'h1, 12'h000, 32'hC3);
        apb(1'h0, 12'h010, 32'h0);
        chk(32'({r[12:8], multi_function_pin}), 32'h1);
        apb(1'h1, 12'h000, 32'h0B);
        rx_timeout <= 1'h1;
        repeat (3) @(posedge pclk);
        chk(32'({rx_data_irq, multi_function_pin}), 32'h2);
        rx_timeout <= 1'h0;
        repeat (3) @(posedge pclk);
        chk(32'(multi_function_pin), 32'h1);
        stall <= 1'h1;
        apb(1'h1, 12'h000, 32'h0D);
        for (int i = 0; i < 16; i++) begin
            apb(1'h1, 12'h004, 32'(8'h10 + i));
            @(posedge pclk);
            chk(32'({e, tx_dma_ready_n, tx_space_irq}), 32'({1'h0, i == 15, i != 15}));
        end
        apb(1'h1, 12'h004, 32'h55);
        chk(32'(e), 32'h1);
        stall <= 1'h0;
        for (int n = 0; n < 200 && got !== 5'h10; n++) @(posedge pclk);
        repeat (2) @(posedge pclk);
        chk(32'({got, last, tx_dma_ready_n}), 32'h203E);
        stall <= 1'h1;
        apb(1'h1, 12'h000, 32'h01);
        repeat (3) apb(1'h1, 12'h004, 32'h33);
        apb(1'h1, 12'h000, 32'h05);
        @(posedge pclk); // ready pin lags the flushed count by a cycle
        apb(1'h0, 12'h010, 32'h0);
        chk(32'({r[4:0], r[16]}), 32'h0);
        apb(1'h1, 12'h004, 32'h77);
        @(posedge pclk);
        chk(32'(tx_dma_ready_n), 32'h1);
        presetn <= 1'h0;
        repeat (2) @(posedge pclk);
        presetn <= 1'h1;
        @(posedge pclk);
        apb(1'h0, 12'h000, 32'h0);
        chk(r, 32'h0);
        // fifos off after reset: one holding word, then the path is full
        apb(1'h1, 12'h004, 32'h11);
        @(posedge pclk);
        chk(32'({e, tx_dma_ready_n}), 32'h1);
        apb(1'h1, 12'h004, 32'h12);
        chk(32'(e), 32'h1);
        results();
    end
endmodule
